// *** design/eep_pkg.sv ***
// constants, types and behaviour summary of the serial eeprom sequencer
// What this block does
// - write select matching acknowledged, then two acknowledged address bytes, then data.
// - high address byte first; address bits above the array width are ignored.
// - programming starts only on stop in the tenth slot after a data acknowledge.
// - after programming the counter points past the last modified byte.
// - while programming the data driver stays off and all bus activity is ignored.
// - write protect high: data bytes get no acknowledge and memory stays unchanged.
// - write protect high still acknowledges select and both address bytes.
// - byte write is one data byte then stop, acknowledged only when unprotected.
// - up to 32 bytes of one page are latched for one programming operation.
// - bytes past the page end wrap to the page start, overwriting earlier bytes.
// - the byte counter advances after every acknowledged data byte of a page write.
// - select is not acknowledged while busy, and acknowledged again once finished.
// - reads run whatever the write protect level is.
// - each completed read byte advances the address counter by one.
// - random read is dummy write of the address, repeated start, read select.
// - a bare read select returns the byte at the counter, then advances.
// - acknowledged read bytes continue with the next byte; no acknowledge ends.
// - sequential reads wrap from the top address to address zero.
// - high level in the ninth read bit stops transmission and returns to standby.
// - the array starts with every byte erased to all ones.
// - respond only when the chip address bits match the chip select inputs.
package eep_pkg;
	localparam int ADDR_W_DEF = 13;
	localparam int PAGE_W = 5;
	localparam logic [5:0] PAGE_BYTES = 6'h20;
	localparam int FIFO_DEPTH_DEF = 32;
	localparam int PROG_CYCLES_DEF = 1000;
	localparam logic [3:0] DEV_TYPE_DEF = 4'h6; // arbitrary value
	localparam logic [7:0] ERASED_BYTE = 8'hff;
	localparam logic [3:0] BYTE_BITS = 4'h8;

	typedef enum logic [3:0] {
		ST_IDLE, ST_DEVSEL, ST_ADDRH, ST_ADDRL, ST_WDATA,
		ST_RDATA, ST_RACK, ST_SKIP, ST_PROG
	} eep_state_t;

	// one latched write byte and its place in the page
	typedef struct packed {
		logic [4:0] offset;
		logic [7:0] data;
	} eep_wr_t;

	// pins sampled from outside the clock domain
	typedef struct packed {
		logic scl;
		logic sda;
		logic wp;
		logic [2:0] cs;
	} eep_pins_t;
endpackage

// *** design/eep_seq.sv ***
// write fifo and serial eeprom command sequencer
`timescale 1ns/1ns

module eep_fifo #(
	parameter int W = 13,
	parameter int DEPTH = 32
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic ce_in,
	// filling side
	input wire logic in_valid_in,
	input wire logic [W-1:0] in_data_in,
	output logic in_ready_out,
	// draining side
	output logic out_valid_out,
	output logic [W-1:0] out_data_out,
	input wire logic out_ready_in
);
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0] store [DEPTH];
	logic [AW:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
	logic full, empty, push, pop;

	// occupancy from pointers with a wrap bit
	assign full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
	assign empty = (wr_ptr == rd_ptr);
	assign in_ready_out = ~full;
	assign out_valid_out = ~empty;
	assign out_data_out = store[rd_ptr[AW-1:0]];
	assign push = ce_in & in_valid_in & ~full;
	assign pop = ce_in & out_ready_in & ~empty;

	// pointer advance
	always_comb begin
		next_wr_ptr = wr_ptr + {{AW{1'b0}}, push};
		next_rd_ptr = rd_ptr + {{AW{1'b0}}, pop};
	end

	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else if (ce_in) begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
		end
	end

	// storage, no reset needed
	always_ff @(posedge clk_in) begin
		if (push) begin
			store[wr_ptr[AW-1:0]] <= in_data_in;
		end
	end
endmodule

module eep_seq #(
	parameter int ADDR_W = eep_pkg::ADDR_W_DEF,
	parameter int FIFO_DEPTH = eep_pkg::FIFO_DEPTH_DEF,
	parameter int PROG_CYCLES = eep_pkg::PROG_CYCLES_DEF,
	parameter logic [3:0] DEV_TYPE = eep_pkg::DEV_TYPE_DEF // arbitrary value
) (
	// clock, reset, enable
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic ce_in,
	// serial bus pins
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_n_out,
	// straps and protect
	input wire logic write_protect_input_in,
	input wire logic chip_select_bit2_in,
	input wire logic chip_select_bit1_in,
	input wire logic chip_select_bit0_in,
	// status
	output logic busy_out
);
	localparam int FW = $bits(eep_pkg::eep_wr_t);
	localparam int WORDS = 1 << ADDR_W;

	eep_pkg::eep_pins_t pin_raw, p1, p2, p3;
	eep_pkg::eep_state_t st, next_st;
	logic [3:0] bitcnt, next_bitcnt;
	logic ack_phase, next_ack_phase;
	logic sda_oe_n, next_sda_oe_n;
	logic read_mode, next_read_mode;
	logic got_data, next_got_data;
	logic [7:0] shift, next_shift;
	logic [7:0] addr_hi, next_addr_hi;
	logic [ADDR_W-1:0] addr, next_addr;
	logic commit_on, next_commit_on;
	logic [5:0] commit_idx, next_commit_idx;
	logic [31:0] prog_cnt, next_prog_cnt;
	logic [31:0] mask, next_mask;
	logic [7:0] page_buf [32];
	logic [7:0] mem [WORDS];
	logic rise, fall, start, stop, match, decide, slot10;
	logic fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_out_ready, pop, commit_we;
	eep_pkg::eep_wr_t fifo_in, fifo_out;
	localparam int PAGE_W_L = eep_pkg::PAGE_W;
	logic [4:0] addr_off;
	logic [ADDR_W-PAGE_W_L-1:0] addr_pg;

	// pin sampling, two flops then an edge flop
	assign pin_raw = '{scl: scl_in, sda: sda_in, wp: write_protect_input_in,
		cs: {chip_select_bit2_in, chip_select_bit1_in, chip_select_bit0_in}};
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			p1 <= '{scl: 1'b1, sda: 1'b1, wp: 1'b0, cs: 3'h0};
			p2 <= '{scl: 1'b1, sda: 1'b1, wp: 1'b0, cs: 3'h0};
			p3 <= '{scl: 1'b1, sda: 1'b1, wp: 1'b0, cs: 3'h0};
		end else if (ce_in) begin
			p1 <= pin_raw;
			p2 <= p1;
			p3 <= p2;
		end
	end

	// bus events seen on the synchronised pins
	assign rise = ce_in & p2.scl & ~p3.scl;
	assign fall = ce_in & ~p2.scl & p3.scl;
	assign start = ce_in & p2.scl & p3.scl & p3.sda & ~p2.sda;
	assign stop = ce_in & p2.scl & p3.scl & ~p3.sda & p2.sda;
	assign match = (shift[7:4] == DEV_TYPE) && (shift[3:1] == p2.cs);
	assign decide = fall && (bitcnt == eep_pkg::BYTE_BITS) && !ack_phase;
	assign slot10 = (st == eep_pkg::ST_WDATA) && (bitcnt == 4'h1) && !ack_phase && got_data;
	assign addr_off = addr[PAGE_W_L-1:0];
	assign addr_pg = addr[ADDR_W-1:PAGE_W_L];

	// accepted data byte goes to the fifo with its page offset
	assign fifo_in = '{offset: addr_off, data: shift};
	assign fifo_in_valid = decide && (st == eep_pkg::ST_WDATA) && !p2.wp && fifo_in_ready;
	assign fifo_out_ready = ~commit_on;
	assign pop = ce_in & fifo_out_valid & fifo_out_ready;
	assign commit_we = ce_in && (st == eep_pkg::ST_PROG) && commit_on
		&& (commit_idx != eep_pkg::PAGE_BYTES) && mask[commit_idx[4:0]];

	eep_fifo #(.W(FW), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk_in(clk_in),
		.sys_rst_in(sys_rst_in),
		.ce_in(ce_in),
		.in_valid_in(fifo_in_valid),
		.in_data_in(fifo_in),
		.in_ready_out(fifo_in_ready),
		.out_valid_out(fifo_out_valid),
		.out_data_out(fifo_out),
		.out_ready_in(fifo_out_ready)
	);

	// sequencer next state
	always_comb begin
		next_st = st;
		next_bitcnt = bitcnt;
		next_ack_phase = ack_phase;
		next_sda_oe_n = sda_oe_n;
		next_read_mode = read_mode;
		next_got_data = got_data;
		next_shift = shift;
		next_addr_hi = addr_hi;
		next_addr = addr;
		next_commit_on = commit_on;
		next_commit_idx = commit_idx;
		next_prog_cnt = prog_cnt;
		if (st == eep_pkg::ST_PROG) begin
			// deaf to the bus until done
			next_sda_oe_n = 1'b1;
			if (!commit_on) begin
				next_commit_on = ~fifo_out_valid;
			end else if (commit_idx != eep_pkg::PAGE_BYTES) begin
				next_commit_idx = commit_idx + 6'h1;
			end else if (prog_cnt == 32'(PROG_CYCLES - 1)) begin
				next_st = eep_pkg::ST_IDLE;
				next_commit_on = 1'b0;
			end else begin
				next_prog_cnt = prog_cnt + 32'h1;
			end
		end else if (start) begin
			next_st = eep_pkg::ST_DEVSEL;
			next_bitcnt = 4'h0;
			next_ack_phase = 1'b0;
			next_sda_oe_n = 1'b1;
			next_got_data = 1'b0;
		end else if (stop) begin
			next_st = slot10 ? eep_pkg::ST_PROG : eep_pkg::ST_IDLE;
			next_ack_phase = 1'b0;
			next_sda_oe_n = 1'b1;
			next_commit_on = 1'b0;
			next_commit_idx = 6'h0;
			next_prog_cnt = 32'h0;
		end else begin
			case (st)
				eep_pkg::ST_DEVSEL, eep_pkg::ST_ADDRH, eep_pkg::ST_ADDRL, eep_pkg::ST_WDATA: begin
					if (rise && bitcnt != eep_pkg::BYTE_BITS) begin
						next_shift = {shift[6:0], p2.sda};
						next_bitcnt = bitcnt + 4'h1;
					end else if (decide) begin
						next_ack_phase = 1'b1;
						if (st == eep_pkg::ST_DEVSEL) begin
							if (match) begin
								next_sda_oe_n = 1'b0;
								next_read_mode = shift[0];
								if (shift[0]) begin
									next_shift = mem[addr];
									next_addr = addr + ADDR_W'(1);
								end
							end else begin
								next_st = eep_pkg::ST_SKIP;
							end
						end else if (st == eep_pkg::ST_ADDRH) begin
							next_sda_oe_n = 1'b0;
							next_addr_hi = shift;
						end else if (st == eep_pkg::ST_ADDRL) begin
							next_sda_oe_n = 1'b0;
							next_addr = ADDR_W'({addr_hi, shift});
						end else if (fifo_in_valid) begin
							next_sda_oe_n = 1'b0;
							next_got_data = 1'b1;
							next_addr = {addr_pg, 5'(addr_off + 5'h1)};
						end
					end else if (fall && ack_phase) begin
						next_ack_phase = 1'b0;
						next_sda_oe_n = 1'b1;
						next_bitcnt = 4'h0;
						if (st == eep_pkg::ST_DEVSEL && read_mode) begin
							next_st = eep_pkg::ST_RDATA;
							next_sda_oe_n = shift[7];
							next_shift = {shift[6:0], 1'b0};
							next_bitcnt = 4'h1;
						end else if (st == eep_pkg::ST_DEVSEL) begin
							next_st = eep_pkg::ST_ADDRH;
						end else if (st == eep_pkg::ST_ADDRH) begin
							next_st = eep_pkg::ST_ADDRL;
						end else begin
							next_st = eep_pkg::ST_WDATA;
						end
					end
				end
				eep_pkg::ST_RDATA: begin
					if (fall && bitcnt == eep_pkg::BYTE_BITS) begin
						next_sda_oe_n = 1'b1;
						next_st = eep_pkg::ST_RACK;
					end else if (fall) begin
						next_sda_oe_n = shift[7];
						next_shift = {shift[6:0], 1'b0};
						next_bitcnt = bitcnt + 4'h1;
					end
				end
				eep_pkg::ST_RACK: begin
					if (rise && p2.sda) begin
						next_st = eep_pkg::ST_IDLE;
					end else if (rise) begin
						next_shift = mem[addr];
						next_addr = addr + ADDR_W'(1);
						next_st = eep_pkg::ST_RDATA;
						next_bitcnt = 4'h0;
					end
				end
				default: begin
					next_st = st;
				end
			endcase
		end
	end

	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			st <= eep_pkg::ST_IDLE;
			bitcnt <= 4'h0;
			ack_phase <= 1'b0;
			sda_oe_n <= 1'b1;
			read_mode <= 1'b0;
			got_data <= 1'b0;
			shift <= 8'h00;
			addr_hi <= 8'h00;
			addr <= '0;
			commit_on <= 1'b0;
			commit_idx <= 6'h0;
			prog_cnt <= 32'h0;
		end else if (ce_in) begin
			st <= next_st;
			bitcnt <= next_bitcnt;
			ack_phase <= next_ack_phase;
			sda_oe_n <= next_sda_oe_n;
			read_mode <= next_read_mode;
			got_data <= next_got_data;
			shift <= next_shift;
			addr_hi <= next_addr_hi;
			addr <= next_addr;
			commit_on <= next_commit_on;
			commit_idx <= next_commit_idx;
			prog_cnt <= next_prog_cnt;
		end
	end

	// page latch valid bits: set by drain, cleared by commit
	always_comb begin
		next_mask = mask;
		// a fresh transfer drops bytes of an unfinished write
		if (start && !busy_out) begin
			next_mask = 32'h0;
		end
		if (pop) begin
			next_mask[fifo_out.offset] = 1'b1;
		end
		if (commit_we) begin
			next_mask[commit_idx[4:0]] = 1'b0;
		end
	end

	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			mask <= 32'h0;
		end else if (ce_in) begin
			mask <= next_mask;
		end
	end

	// later bytes at the same offset replace earlier ones
	always_ff @(posedge clk_in) begin
		if (pop) begin
			page_buf[fifo_out.offset] <= fifo_out.data;
		end
	end

	// array starts erased
	initial begin
		for (int i = 0; i < WORDS; i++) begin
			mem[i] = eep_pkg::ERASED_BYTE;
		end
	end

	// programming writes the latched page into the array
	always_ff @(posedge clk_in) begin
		if (commit_we) begin
			mem[{addr_pg, commit_idx[4:0]}] <= page_buf[commit_idx[4:0]];
		end
	end

	// open-drain data pin: only ever pulls low
	assign sda_out = 1'b0;
	assign sda_oe_n_out = sda_oe_n;
	assign busy_out = (st == eep_pkg::ST_PROG);

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (sys_rst_in);

	sequence s_rack_ok;
		rise && (st == eep_pkg::ST_RACK) && !p2.sda;
	endsequence
	sequence s_wr_take;
		decide && (st == eep_pkg::ST_WDATA) && !p2.wp && fifo_in_ready;
	endsequence

	property p_prog_quiet;
		busy_out |-> sda_oe_n_out;
	endproperty
	a_prog_quiet: assert property (p_prog_quiet) else $error("driver on while programming");
	property p_prog_deaf;
		busy_out && start |=> st != eep_pkg::ST_DEVSEL;
	endproperty
	a_prog_deaf: assert property (p_prog_deaf) else $error("start taken while busy");
	property p_prog_hold;
		$rose(busy_out) |-> busy_out[*8];
	endproperty
	a_prog_hold: assert property (p_prog_hold) else $error("programming ended too soon");
	property p_slot10;
		stop && slot10 && !busy_out |=> busy_out;
	endproperty
	a_slot10: assert property (p_slot10) else $error("stop after data did not program");
	property p_no_trigger;
		stop && !slot10 && !busy_out |=> st == eep_pkg::ST_IDLE;
	endproperty
	a_no_trigger: assert property (p_no_trigger) else $error("stop in wrong slot programmed");
	property p_wp_nack;
		decide && (st == eep_pkg::ST_WDATA) && p2.wp |=> sda_oe_n_out ##1 sda_oe_n_out;
	endproperty
	a_wp_nack: assert property (p_wp_nack) else $error("protected byte acknowledged");
	property p_addr_ack;
		decide && (st == eep_pkg::ST_ADDRH || st == eep_pkg::ST_ADDRL) |=> !sda_oe_n_out;
	endproperty
	a_addr_ack: assert property (p_addr_ack) else $error("address byte not acknowledged");
	property p_sel_miss;
		decide && (st == eep_pkg::ST_DEVSEL) && !match |=> sda_oe_n_out && st == eep_pkg::ST_SKIP;
	endproperty
	a_sel_miss: assert property (p_sel_miss) else $error("foreign select answered");
	property p_rd_nack;
		rise && (st == eep_pkg::ST_RACK) && p2.sda |=> st == eep_pkg::ST_IDLE && sda_oe_n_out;
	endproperty
	a_rd_nack: assert property (p_rd_nack) else $error("read went on after no acknowledge");
	property p_rd_next;
		s_rack_ok |=> addr == ADDR_W'($past(addr) + 1'b1);
	endproperty
	a_rd_next: assert property (p_rd_next) else $error("read counter did not advance");
	property p_wr_step;
		s_wr_take |=> addr_off == 5'($past(addr_off) + 5'h1) && addr_pg == $past(addr_pg);
	endproperty
	a_wr_step: assert property (p_wr_step) else $error("write counter left the page");
endmodule

// *** tb/eep_master.sv ***
// bus master model driving the serial clock and pulling the data line
`timescale 1ns/1ns
module eep_master #(
	parameter logic [3:0] DEV_TYPE = 4'h9 // arbitrary value
) (
	// clock
	input wire logic clk_in,
	// bus wires
	input wire logic sda_in,
	output logic scl_out,
	output logic sda_low_out
);
	// bus idle: clock high and data released to its pull-up
	initial begin
		scl_out = 1'b1;
		sda_low_out = 1'b0;
	end
	// wait falling clock edges
	task automatic tick(input int n);
		repeat (n) @(negedge clk_in);
	endtask
	// start or repeated start, leaves the clock low
	task automatic start();
		sda_low_out = 1'b0;
		tick(2);
		scl_out = 1'b1;
		tick(4);
		sda_low_out = 1'b1;
		tick(4);
		scl_out = 1'b0;
		tick(2);
	endtask
	// stop, leaves the bus idle and the clock standing high
	task automatic stop();
		sda_low_out = 1'b1;
		tick(2);
		scl_out = 1'b1;
		tick(4);
		sda_low_out = 1'b0;
		tick(4);
	endtask
	// one bit out, data changed only while the clock is low
	task automatic bit_out(input logic b);
		sda_low_out = ~b;
		tick(2);
		scl_out = 1'b1;
		tick(4);
		scl_out = 1'b0;
		tick(2);
	endtask
	// one bit in, sampled mid high phase
	task automatic bit_in(output logic b);
		sda_low_out = 1'b0;
		tick(2);
		scl_out = 1'b1;
		tick(2);
		b = sda_in;
		tick(2);
		scl_out = 1'b0;
		tick(2);
	endtask
	// byte out msb first, then the ninth bit
	task automatic wr_byte(input logic [7:0] d, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			bit_out(d[i]);
		end
		bit_in(ack);
		ack = ~ack;
	endtask
	// byte in, then ack to continue or release to end
	task automatic rd_byte(output logic [7:0] d, input logic ack);
		for (int i = 7; i >= 0; i--) begin
			bit_in(d[i]);
		end
		bit_out(~ack);
	endtask
	// start and select byte
	task automatic sel(input logic [2:0] cs, input logic rw, output logic ack);
		start();
		wr_byte({DEV_TYPE, cs, rw}, ack);
	endtask
	// write select then high and low address bytes, no stop
	task automatic addr_phase(input logic [2:0] cs, input logic [15:0] a, output logic ok);
		logic k1;
		logic k2;
		logic k3;
		sel(cs, 1'b0, k1);
		wr_byte(a[15:8], k2);
		wr_byte(a[7:0], k3);
		ok = k1 & k2 & k3;
	endtask
endmodule

// *** tb/tb_eep_seq.sv ***
// self-checking bench for the serial eeprom sequencer
`timescale 1ns/1ns
module tb_eep_seq;
	localparam logic [3:0] DEV = 4'h9; // arbitrary value
	localparam int PROG = 20;
	typedef struct packed {
		logic [15:0] wa;
		logic [15:0] ra;
		logic [7:0] d;
	} eep_row_t;
	localparam eep_row_t ROWS [4] = '{
		'{16'h0000, 16'h0000, 8'h3c},
		'{16'he001, 16'h0001, 8'hc3},
		'{16'h1234, 16'h1234, 8'ha5},
		'{16'h1fff, 16'h1fff, 8'h00}};
	// bench signals
	logic clk_in = 1'b0;
	logic sys_rst_in = 1'b1;
	logic ce = 1'b1;
	logic wp = 1'b0;
	logic [2:0] straps = 3'h5;
	logic scl;
	logic sda_low;
	logic sda;
	logic sda_out;
	logic sda_oe_n_out;
	logic busy_out;
	int errors = 0;
	int checks_done = 0;
	logic [7:0] q [$];
	logic [7:0] b;
	logic ok;
	int n;
	always #50 clk_in = ~clk_in;
	// open drain wire with pull-up
	assign sda = (sda_low || (sda_oe_n_out == 1'b0 && sda_out == 1'b0)) ? 1'b0 : 1'b1;
	eep_seq #(.PROG_CYCLES(PROG), .DEV_TYPE(DEV)) dut_u (
		.clk_in(clk_in), .sys_rst_in(sys_rst_in), .ce_in(ce),
		.scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe_n_out(sda_oe_n_out),
		.write_protect_input_in(wp), .chip_select_bit2_in(straps[2]),
		.chip_select_bit1_in(straps[1]), .chip_select_bit0_in(straps[0]), .busy_out(busy_out));
	eep_master #(.DEV_TYPE(DEV)) m_u (.clk_in(clk_in), .sda_in(sda), .scl_out(scl), .sda_low_out(sda_low));
	// verdict and end of run
	task automatic end_sim();
		if (errors == 0 && checks_done > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// one comparison
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	// bounded wait for programming to finish
	task automatic wait_idle();
		int c;
		c = 0;
		while (busy_out !== 1'b0 && c < 200) begin
			@(negedge clk_in);
			c++;
		end
		if (c >= 200) begin
			errors++;
			end_sim();
		end
	endtask
	// write n bytes from d0 upwards, stop in the tenth slot
	task automatic write_seq(input logic [15:0] a, input int cnt, input logic [7:0] d0, input logic ack_exp);
		logic k;
		m_u.addr_phase(straps, a, k);
		chk("addr ack", 1, k);
		for (int i = 0; i < cnt; i++) begin
			m_u.wr_byte(d0 + 8'(i), k);
			chk("data ack", ack_exp, k);
		end
		m_u.stop();
		chk("busy", ack_exp, busy_out);
	endtask
	// random or current address read of cnt bytes
	task automatic read_seq(input logic rnd, input logic [15:0] a, input int cnt);
		logic k;
		logic [7:0] d;
		q = {};
		if (rnd) begin
			m_u.addr_phase(straps, a, k);
			chk("dummy ack", 1, k);
		end
		m_u.sel(straps, 1'b1, k);
		chk("read sel ack", 1, k);
		for (int i = 0; i < cnt; i++) begin
			m_u.rd_byte(d, i < cnt - 1);
			q.push_back(d);
		end
		m_u.stop();
	endtask
	// hang guard
	initial begin
		#5000000;
		errors++;
		end_sim();
	end
	// main sequence
	initial begin
		repeat (10) @(negedge clk_in);
		chk("busy in reset", 0, busy_out);
		chk("drive in reset", 1, sda_oe_n_out);
		chk("pull value", 0, sda_out);
		sys_rst_in = 1'b0;
		m_u.tick(4);
		read_seq(1'b1, 16'h0100, 1);
		chk("erased", 8'hff, q[0]);
		// ordinary byte writes and read-backs
		foreach (ROWS[r]) begin
			write_seq(ROWS[r].wa, 1, ROWS[r].d, 1'b1);
			wait_idle();
			read_seq(1'b1, ROWS[r].ra, 1);
			chk("row", ROWS[r].d, q[0]);
		end
		// sequential read across the top address, then current read
		read_seq(1'b1, 16'h1fff, 2);
		chk("top byte", 8'h00, q[0]);
		chk("wrapped byte", 8'h3c, q[1]);
		read_seq(1'b0, 16'h0000, 1);
		chk("current", 8'hc3, q[0]);
		// acknowledge polling during programming
		write_seq(16'h0040, 1, 8'h5a, 1'b1);
		m_u.sel(straps, 1'b1, ok);
		chk("sel while busy", 0, ok);
		n = 0;
		while (ok !== 1'b1 && n < 20) begin
			m_u.sel(straps, 1'b1, ok);
			n++;
		end
		chk("poll ack", 1, ok);
		m_u.rd_byte(b, 1'b0);
		m_u.stop();
		chk("after written", 8'hff, b);
		// page roll-over: 34 bytes from offset 30
		write_seq(16'h009e, 34, 8'h00, 1'b1);
		// clock enable low freezes programming
		ce = 1'b0;
		m_u.tick(100);
		chk("frozen", 1, busy_out);
		ce = 1'b1;
		wait_idle();
		read_seq(1'b1, 16'h0080, 32);
		for (int o = 0; o < 32; o++) begin
			chk("page", 16'(o + 2), q[o]);
		end
		// protected write leaves memory alone, reads still run
		wp = 1'b1;
		write_seq(16'h0080, 2, 8'h77, 1'b0);
		read_seq(1'b1, 16'h0080, 1);
		chk("protected", 8'h02, q[0]);
		wp = 1'b0;
		// stop after address bytes starts nothing
		m_u.addr_phase(straps, 16'h0300, ok);
		m_u.stop();
		chk("early stop", 0, busy_out);
		// foreign chip address and foreign type
		m_u.sel(straps ^ 3'h1, 1'b1, ok);
		m_u.stop();
		chk("foreign chip", 0, ok);
		m_u.start();
		m_u.wr_byte({~DEV, straps, 1'b1}, ok);
		m_u.stop();
		chk("foreign type", 0, ok);
		// reset in mid-run: outputs quiet, counter back to zero
		sys_rst_in = 1'b1;
		m_u.tick(3);
		chk("busy in mid reset", 0, busy_out);
		chk("drive in mid reset", 1, sda_oe_n_out);
		sys_rst_in = 1'b0;
		m_u.tick(4);
		read_seq(1'b0, 16'h0000, 1);
		chk("counter after reset", 8'h3c, q[0]);
		straps = 3'h2;
		m_u.sel(3'h2, 1'b1, ok);
		chk("new straps", 1, ok);
		m_u.rd_byte(b, 1'b0);
		m_u.stop();
		end_sim();
	end
endmodule
